// *** rtl/spi_id_pkg.sv ***
// Constants and types for the flash power-down and ID command block.
// Assumes a 250 MHz core clock and a host-driven serial clock.
package spi_id_pkg;

	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_PDOWN   = 8'hB9;
	localparam logic [7:0] OP_RELEASE = 8'hAB;
	localparam logic [7:0] OP_MFR1    = 8'h90;
	localparam logic [7:0] OP_MFR2    = 8'h92;
	localparam logic [7:0] OP_MFR4    = 8'h94;
	localparam logic [7:0] OP_JEDEC   = 8'h9F;

	// ------------------------------------------------------------
	// Serial clock counts within a frame
	// ------------------------------------------------------------
	localparam logic [5:0] CNT_ZERO    = 6'h00;
	localparam logic [5:0] CNT_ONE     = 6'h01;
	localparam logic [5:0] CNT_MAX     = 6'h3F;
	localparam logic [5:0] OPC_LAST    = 6'h07;
	localparam logic [5:0] OPC_DONE    = 6'h08;
	localparam logic [5:0] START_STD   = 6'h20;
	localparam logic [5:0] START_DUAL  = 6'h18;
	localparam logic [5:0] START_QUAD  = 6'h14;
	localparam logic [5:0] START_JEDEC = 6'h08;
	localparam logic [5:0] A0_STD      = 6'h1F;
	localparam logic [5:0] A0_DUAL     = 6'h13;
	localparam logic [5:0] A0_QUAD     = 6'h0D;
	localparam logic [2:0] LAST_SLOT1  = 3'h7;
	localparam logic [2:0] LAST_SLOT2  = 3'h3;
	localparam logic [2:0] LAST_SLOT4  = 3'h1;
	localparam logic [1:0] SEQ_LAST3   = 2'h2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS            = 4000;
	localparam int POWER_DOWN_ENTRY_TIME_NS = 3000;
	localparam int RELEASE_TIME_NS          = 3000;
	localparam int RELEASE_WITH_ID_TIME_NS  = 5000;
	localparam int ENTRY_CYC  = (POWER_DOWN_ENTRY_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int REL_CYC    = (RELEASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REL_ID_CYC =
		(RELEASE_WITH_ID_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		CMD_NONE = 7'h01, CMD_PDOWN = 7'h02, CMD_REL = 7'h04, CMD_MFR1 = 7'h08,
		CMD_MFR2 = 7'h10, CMD_MFR4 = 7'h20, CMD_JEDEC = 7'h40
	} cmd_type;
	typedef enum logic [3:0] {
		ST_NORMAL = 4'h1, ST_ENTER = 4'h2, ST_DOWN = 4'h4, ST_RELEASE = 4'h8
	} pwr_type;
	typedef struct packed {
		cmd_type    cmd;
		logic [5:0] clocks;
	} frame_type;
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} pins_type;
	typedef struct packed {
		logic pd;
		logic ok;
		logic busy;
	} status_type;

endpackage

// *** rtl/spi_flash_power_id.sv ***
// Power-down, release and identification command handling of a serial flash.
// Assumes the host drives csN, sclk and the four data lines; the array logic
// beside this block pulses cycleStart and cycleDone around program or erase.
//
// Contract
// RL1: Opcode B9h decodes as the power-down command.
// RL2: Power-down only if select rises after eight bits.
// RL3: Power-down state reached within the entry time.
// RL4: Powered down, only ABh is recognised.
// RL5: Power-up lands in normal operation.
// RL6: Plain release waits the release time.
// RL7: ABh plus three dummies returns device ID MSB-first.
// RL8: ABh read repeats device ID until select rises.
// RL9: Release with readout waits the longer time.
// RL10: ABh ignored while write in progress.
// RL11: 90h plus address returns ID bytes single-line.
// RL12: Address bit zero picks which ID byte first.
// RL13: ID bytes alternate until select rises.
// RL14: 92h takes two-bit address, four dummies, dual out.
// RL15: 94h takes four-bit address, six dummies, quad out.
// RL16: Mode bits after the address are ignored.
// RL17: 9Fh returns maker, memory type, capacity bytes.
// RL18: Write-in-progress held for whole self-timed cycle.
// RL19: Input bits sampled on rising serial clock.
`timescale 1ns/1ns
module spi_flash_power_id
	import spi_id_pkg::*;
#(
	parameter logic [7:0] MFR_ID    = 8'h5A, // Arbitrary maker code
	parameter logic [7:0] DEV_ID    = 8'h13, // Arbitrary device code
	parameter logic [7:0] MEM_TYPE  = 8'h40, // Arbitrary memory type code
	parameter logic [7:0] CAPACITY  = 8'h13, // Arbitrary capacity code
	parameter int         ENTRY_C   = ENTRY_CYC,
	parameter int         REL_C     = REL_CYC,
	parameter int         REL_ID_C  = REL_ID_CYC
) (
	input  wire logic       ref_clk,         // Core clock, 250 MHz
	input  wire logic       rst_n,           // Async reset, active low
	input  wire logic       sclk,            // Serial clock from host
	input  wire logic       csN,             // Chip select, active low
	input  wire logic [3:0] ioIn,            // Data lines, pin level
	output logic      [3:0] ioOut,           // Data lines, driven value
	output logic      [3:0] ioOe,            // Data lines, drive enable
	input  wire logic       cycleStart,      // Array cycle begins, pulse
	input  wire logic       cycleDone,       // Array cycle ends, pulse
	output logic            writeInProgress, // Self-timed cycle busy
	output logic            powerDown        // Deep power-down state
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Opcode decode, gated by power state and readiness
	function automatic cmd_type decode(input logic [7:0] op, input status_type st);
		cmd_type res;
		res = CMD_NONE;
		if (st.ok) begin
			if (op == OP_RELEASE) begin
				res = st.busy ? CMD_NONE : CMD_REL; // RL10
			end else if (!st.pd) begin
				unique case (op)
					OP_PDOWN: res = CMD_PDOWN; // RL1
					OP_MFR1:  res = CMD_MFR1;
					OP_MFR2:  res = CMD_MFR2;
					OP_MFR4:  res = CMD_MFR4;
					OP_JEDEC: res = CMD_JEDEC;
					default:  res = CMD_NONE;
				endcase
			end
		end
		return res; // RL4
	endfunction

	// Next position in the byte sequence of a read
	function automatic logic [1:0] seqStep(input cmd_type c, input logic [1:0] s);
		logic [1:0] res;
		res = {1'b0, ~s[0]};
		if (c == CMD_JEDEC) begin
			res = (s == SEQ_LAST3) ? 2'b00 : s + 2'b01;
		end
		return res;
	endfunction

	// ------------------------------------------------------------
	// Serial side: frame counter and opcode shifter
	// ------------------------------------------------------------
	logic       frameRst;
	logic [5:0] riseCntFf;
	logic [5:0] nxt_riseCnt;
	logic [6:0] opShFf;
	logic [6:0] nxt_opSh;
	logic [7:0] opcode;
	logic       addr0Ff;
	logic       nxt_addr0;
	logic [5:0] a0Idx;
	cmd_type    cmdFf;
	cmd_type    nxt_cmd;
	logic [5:0] clocksFf;
	status_type statusMetaFf;
	status_type statusFf;
	status_type statusCore;

	// Select high ends the frame; it also covers a core reset
	assign frameRst = csN | ~rst_n;

	// Count rising edges, stop at the top
	assign nxt_riseCnt = (riseCntFf == CNT_MAX) ? riseCntFf : riseCntFf + CNT_ONE;
	assign nxt_opSh    = (riseCntFf < OPC_DONE) ? {opShFf[5:0], ioIn[0]} : opShFf;
	assign opcode      = {opShFf, ioIn[0]};

	// Last address bit position per read; mode bits come later
	assign a0Idx = (cmdFf == CMD_MFR1) ? A0_STD :
		(cmdFf == CMD_MFR2) ? A0_DUAL :
		(cmdFf == CMD_MFR4) ? A0_QUAD : CNT_MAX; // RL16
	assign nxt_addr0 = (riseCntFf == a0Idx) ? ioIn[0] : addr0Ff; // RL12

	// Command fixed on the eighth edge, cleared on the first
	assign nxt_cmd = (riseCntFf == OPC_LAST) ? decode(opcode, statusFf) :
		(riseCntFf == CNT_ZERO) ? CMD_NONE : cmdFf;

	// Frame state; inputs latched on the rising edge
	always_ff @(posedge sclk or posedge frameRst) begin
		if (frameRst) begin
			riseCntFf <= CNT_ZERO;
			opShFf    <= '0;
			addr0Ff   <= 1'b0;
		end else begin
			riseCntFf <= nxt_riseCnt; // RL19
			opShFf    <= nxt_opSh;
			addr0Ff   <= nxt_addr0;
		end
	end

	// Command and length survive select rising so the core can read them
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			cmdFf    <= CMD_NONE;
			clocksFf <= CNT_ZERO;
		end else begin
			cmdFf    <= nxt_cmd;
			clocksFf <= nxt_riseCnt;
		end
	end

	// Core status into the serial domain; settles long before edge eight
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			statusMetaFf <= '{pd: 1'b0, ok: 1'b1, busy: 1'b0};
			statusFf     <= '{pd: 1'b0, ok: 1'b1, busy: 1'b0};
		end else begin
			statusMetaFf <= statusCore;
			statusFf     <= statusMetaFf;
		end
	end

	// ------------------------------------------------------------
	// Serial side: readout on the falling edge
	// ------------------------------------------------------------
	logic       isRead;
	logic [5:0] startIdx;
	logic [2:0] lastSlot;
	logic       startHere;
	logic       outOnFf;
	logic       nxt_outOn;
	logic [2:0] slotFf;
	logic [2:0] nxt_slot;
	logic [1:0] seqFf;
	logic [1:0] nxt_seq;
	logic       byteEnd;
	logic [7:0] curByte;
	logic [2:0] shamt;
	logic [7:0] shifted;
	pins_type   pinsFf;
	pins_type   nxt_pins;

	assign isRead = (cmdFf != CMD_NONE) && (cmdFf != CMD_PDOWN);

	// First output clock per command, after opcode, address, dummies
	assign startIdx = (cmdFf == CMD_MFR2) ? START_DUAL : // RL14
		(cmdFf == CMD_MFR4) ? START_QUAD : // RL15
		(cmdFf == CMD_JEDEC) ? START_JEDEC : START_STD; // RL7 RL11
	assign lastSlot = (cmdFf == CMD_MFR2) ? LAST_SLOT2 :
		(cmdFf == CMD_MFR4) ? LAST_SLOT4 : LAST_SLOT1;
	assign startHere = isRead && (riseCntFf == startIdx);

	// Slot and byte sequence; wraps forever until select rises
	assign byteEnd   = outOnFf && (slotFf == lastSlot);
	assign nxt_outOn = outOnFf | startHere;
	assign nxt_slot  = (!outOnFf || byteEnd) ? 3'h0 : slotFf + 3'h1;
	assign nxt_seq   = !outOnFf ? 2'b00 :
		byteEnd ? seqStep(cmdFf, seqFf) : seqFf; // RL8 RL13

	// Byte at the current sequence position
	assign curByte = (cmdFf == CMD_REL) ? DEV_ID : // RL8
		(cmdFf == CMD_JEDEC) ? ((nxt_seq == 2'b00) ? MFR_ID : // RL17
		(nxt_seq == 2'b01) ? MEM_TYPE : CAPACITY) :
		(nxt_seq[0] ^ addr0Ff) ? DEV_ID : MFR_ID; // RL12 RL13

	// MSB first, one, two or four bits per clock
	assign shamt = (cmdFf == CMD_MFR2) ? {nxt_slot[1:0], 1'b0} :
		(cmdFf == CMD_MFR4) ? {nxt_slot[0], 2'b00} : nxt_slot;
	assign shifted = curByte << shamt;

	// Lane mapping; single-line data leaves on the second line
	always_comb begin
		nxt_pins = '0;
		if (nxt_outOn) begin
			if (cmdFf == CMD_MFR4) begin
				nxt_pins.out = shifted[7:4]; // RL15
				nxt_pins.oe  = 4'hF;
			end else if (cmdFf == CMD_MFR2) begin
				nxt_pins.out = {2'b00, shifted[7:6]}; // RL14
				nxt_pins.oe  = 4'h3;
			end else begin
				nxt_pins.out = {2'b00, shifted[7], 1'b0}; // RL7
				nxt_pins.oe  = 4'h2;
			end
		end
	end

	// Output registers move on the falling edge
	always_ff @(negedge sclk or posedge frameRst) begin
		if (frameRst) begin
			outOnFf <= 1'b0;
			slotFf  <= 3'h0;
			seqFf   <= 2'b00;
			pinsFf  <= '0;
		end else begin
			outOnFf <= nxt_outOn;
			slotFf  <= nxt_slot;
			seqFf   <= nxt_seq;
			pinsFf  <= nxt_pins;
		end
	end

	assign ioOut = pinsFf.out;
	assign ioOe  = pinsFf.oe;

	// ------------------------------------------------------------
	// Core side: frame end and frame summary
	// ------------------------------------------------------------
	logic [1:0] csSyncFf;
	logic       csPrevFf;
	logic       csRise;
	frame_type  infoMetaFf;
	frame_type  infoFf;
	logic       onBoundary;
	logic       longFrame;

	// Summary words are static once select rises; sync just re-times them
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			csSyncFf   <= 2'b11;
			csPrevFf   <= 1'b1;
			infoMetaFf <= '{cmd: CMD_NONE, clocks: CNT_ZERO};
			infoFf     <= '{cmd: CMD_NONE, clocks: CNT_ZERO};
		end else begin
			csSyncFf   <= {csSyncFf[0], csN};
			csPrevFf   <= csSyncFf[1];
			infoMetaFf <= '{cmd: cmdFf, clocks: clocksFf};
			infoFf     <= infoMetaFf;
		end
	end

	assign csRise     = csSyncFf[1] & ~csPrevFf;
	assign onBoundary = (infoFf.clocks == OPC_DONE); // RL2
	assign longFrame  = (infoFf.clocks > OPC_DONE);

	// ------------------------------------------------------------
	// Core side: write-in-progress flag
	// ------------------------------------------------------------
	logic busyFf;
	logic nxt_busy;

	// Start wins over done when both arrive together
	assign nxt_busy = cycleStart | (busyFf & ~cycleDone); // RL18

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busyFf <= 1'b0;
		end else begin
			busyFf <= nxt_busy;
		end
	end

	assign writeInProgress = busyFf;

	// ------------------------------------------------------------
	// Core side: power state machine
	// ------------------------------------------------------------
	pwr_type     stateFf;
	pwr_type     nxt_state;
	logic [15:0] timerFf;
	logic [15:0] nxt_timer;
	logic        timerDone;
	logic        goDown;
	logic        goUp;

	assign timerDone = (timerFf == 16'h0000);

	// Entry needs an exact eight-clock frame
	assign goDown = csRise && (infoFf.cmd == CMD_PDOWN) && onBoundary; // RL1 RL2

	// Release refused while an array cycle runs
	assign goUp = csRise && (infoFf.cmd == CMD_REL) && !busyFf; // RL10

	always_comb begin
		nxt_state = stateFf;
		nxt_timer = timerDone ? timerFf : timerFf - 16'h0001;
		unique case (stateFf)
			ST_NORMAL: begin
				if (goDown) begin
					nxt_state = ST_ENTER;
					nxt_timer = 16'(ENTRY_C - 1); // RL3
				end
			end
			ST_ENTER: begin
				if (timerDone) begin
					nxt_state = ST_DOWN; // RL3
				end
			end
			ST_DOWN: begin
				if (goUp) begin
					nxt_state = ST_RELEASE;
					nxt_timer = longFrame ? 16'(REL_ID_C - 1) : 16'(REL_C - 1); // RL6 RL9
				end
			end
			ST_RELEASE: begin
				if (timerDone) begin
					nxt_state = ST_NORMAL; // RL6 RL9
				end
			end
			default: begin
				nxt_state = ST_NORMAL;
			end
		endcase
	end

	// Power-up always lands in normal operation
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateFf <= ST_NORMAL; // RL5
			timerFf <= 16'h0000;
		end else begin
			stateFf <= nxt_state;
			timerFf <= nxt_timer;
		end
	end

	// Status toward the serial side; ok low while entering or releasing, busy from the array flag
	assign statusCore.pd   = (stateFf == ST_DOWN); // RL4
	assign statusCore.ok   = (stateFf == ST_NORMAL) || (stateFf == ST_DOWN); // RL6 RL9
	assign statusCore.busy = busyFf; // RL10
	assign powerDown       = (stateFf == ST_DOWN); // RL4

endmodule

// *** tb/spi_flash_power_id_props.sv ***
// Checker for the flash power-down and ID block.
// Assumes it is bound to spi_flash_power_id and sees only its ports.
`timescale 1ns/1ns
module spi_flash_power_id_props
	import spi_id_pkg::*;
#(
	parameter logic [7:0] MFR_ID = 8'h5A, // Maker code, arbitrary
	parameter logic [7:0] DEV_ID = 8'h13  // Device code, arbitrary
) (
	input wire logic       ref_clk,         // Core clock
	input wire logic       rst_n,           // Async reset, active low
	input wire logic       sclk,            // Link clock
	input wire logic       csN,             // Chip select
	input wire logic [3:0] ioIn,            // Pin levels
	input wire logic [3:0] ioOut,           // Driven values
	input wire logic [3:0] ioOe,            // Drive enables
	input wire logic       cycleStart,      // Array cycle begins
	input wire logic       cycleDone,       // Array cycle ends
	input wire logic       writeInProgress, // Busy flag
	input wire logic       powerDown        // Deep power-down
);
	// ------------------------------------------------------------
	// Frame tracking, cleared by select high like the block's own
	// ------------------------------------------------------------
	logic [5:0] edgeCnt_ff; // Rising edges in frame
	logic [7:0] opcode_ff;  // Opcode bits so far
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			edgeCnt_ff <= 6'h00;
			opcode_ff  <= 8'h00;
		end else begin
			if (edgeCnt_ff != 6'h3F) edgeCnt_ff <= edgeCnt_ff + 6'h01;
			if (edgeCnt_ff < 6'h08) opcode_ff <= {opcode_ff[6:0], ioIn[0]};
		end
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	chk_busy_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cycleStart |=> writeInProgress) else $error("busy flag not raised");
	chk_busy_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cycleDone && !cycleStart |=> !writeInProgress) else $error("busy flag not cleared");
	chk_busy_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!cycleStart && !cycleDone |=> $stable(writeInProgress)) else $error("busy flag moved");
	chk_oe_deselect: assert property (@(posedge ref_clk) disable iff (!rst_n)
		csN && $past(csN) |-> ioOe == 4'h0) else $error("drive while deselected");
	chk_opcode_quiet: assert property (@(posedge sclk) disable iff (!rst_n || csN)
		edgeCnt_ff < 6'h08 |-> ioOe == 4'h0) else $error("drive during opcode");
	chk_jedec_first: assert property (@(posedge sclk) disable iff (!rst_n || csN)
		edgeCnt_ff == 6'h08 && opcode_ff == OP_JEDEC && !powerDown
		|-> ioOe == 4'h2 && ioOut[1] == MFR_ID[7]) else $error("maker byte not first");
	chk_single_lane: assert property (@(posedge sclk) disable iff (!rst_n || csN)
		edgeCnt_ff == 6'h20 && opcode_ff == OP_MFR1 && !powerDown
		|-> ioOe == 4'h2) else $error("single read lane wrong");
	chk_dual_lane: assert property (@(posedge sclk) disable iff (!rst_n || csN)
		edgeCnt_ff == 6'h18 && opcode_ff == OP_MFR2 && !powerDown
		|-> ioOe == 4'h3) else $error("dual read lanes wrong");
	chk_quad_lane: assert property (@(posedge sclk) disable iff (!rst_n || csN)
		edgeCnt_ff == 6'h14 && opcode_ff == OP_MFR4 && !powerDown
		|-> ioOe == 4'hF) else $error("quad read lanes wrong");
	chk_devid_msb: assert property (@(posedge sclk) disable iff (!rst_n || csN)
		edgeCnt_ff == 6'h20 && opcode_ff == OP_RELEASE && !writeInProgress
		|-> ioOe == 4'h2 && ioOut[1] == DEV_ID[7]) else $error("device byte missing");
endmodule
bind spi_flash_power_id spi_flash_power_id_props #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID)) u_props (
	.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
	.ioOe(ioOe), .cycleStart(cycleStart), .cycleDone(cycleDone),
	.writeInProgress(writeInProgress), .powerDown(powerDown));

// *** tb/spi_host_model.sv ***
// Host model: drives select, link clock and the data lines.
// Assumes the device drives a line only while its enable is high.
`timescale 1ns/1ns
module spi_host_model (
	output logic            sclk,   // Link clock, idle low
	output logic            csN,    // Chip select, active low
	output logic      [3:0] ioIn,   // Resolved pin levels
	input  wire logic [3:0] ioOut,  // Device values
	input  wire logic [3:0] ioOe,   // Device enables
	output logic            oeSeen  // Device drove in frame
);
	logic [3:0] drv; // Host level of each line
	// Device wins where it drives
	assign ioIn = (ioOe & ioOut) | (~ioOe & drv);
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		drv = 4'h0;
		oeSeen = 1'b0;
	end
	always @(posedge sclk) begin
		if (ioOe != 4'h0) oeSeen = 1'b1;
	end
	// One frame; clock stands still outside it
	task automatic frame(input logic [7:0] op, input int w, input int aClk,
		input logic [23:0] addr, input int dClk, input int rClk, output logic [31:0] rd);
		logic [31:0] a;
		int n;
		a = {addr, 8'hFF}; // Mode bits all ones, then zero dummies
		n = 8 + aClk + dClk;
		rd = 32'h0;
		oeSeen = 1'b0;
		csN = 1'b0;
		for (int i = 0; i < n + rClk; i++) begin
			if (i < 8) drv = {3'b000, op[7 - i]};
			else if (i < n) begin
				drv = (w == 4) ? a[31:28] : (w == 2) ? {2'b00, a[31:30]} : {3'b000, a[31]};
				a = a << w;
			end else drv = ~drv; // Released: toggle so stale levels never pass
			#31 sclk = 1'b1;
			if (i >= n && w == 4) rd = {rd[27:0], ioIn};
			else if (i >= n && w == 2) rd = {rd[29:0], ioIn[1:0]};
			else if (i >= n) rd = {rd[30:0], ioIn[1]};
			#62 sclk = 1'b0;
			#32;
		end
		csN = 1'b1;
		drv = ~drv;
		#20;
	endtask
endmodule

// *** tb/spi_flash_power_id_tb.sv ***
// Self-checking bench for the flash power-down and ID block.
// Assumes the host model makes every frame; short timing counts.
`timescale 1ns/1ns
module spi_flash_power_id_tb;
	import spi_id_pkg::*;
	localparam logic [7:0] MF = 8'hC3; // Arbitrary maker code
	localparam logic [7:0] DV = 8'h2D; // Arbitrary device code
	localparam logic [7:0] MT = 8'h71; // Arbitrary memory type
	localparam logic [7:0] CP = 8'h15; // Arbitrary capacity
	logic        ref_clk, rst_n, sclk, csN, cycleStart, cycleDone, oeSeen;
	logic        writeInProgress, powerDown;
	logic [3:0]  ioIn, ioOut, ioOe;
	logic [31:0] rd;
	int          miscompares, samplesChecked;
	always #2 ref_clk = ~ref_clk;
	spi_flash_power_id #(.MFR_ID(MF), .DEV_ID(DV), .MEM_TYPE(MT), .CAPACITY(CP),
		.ENTRY_C(4), .REL_C(4), .REL_ID_C(8)) u_spi_flash_power_id (
		.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .ioIn(ioIn),
		.ioOut(ioOut), .ioOe(ioOe), .cycleStart(cycleStart), .cycleDone(cycleDone),
		.writeInProgress(writeInProgress), .powerDown(powerDown));
	spi_host_model u_spi_host_model (.sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
		.ioOe(ioOe), .oeSeen(oeSeen));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Bounded wait; a miss ends the run
	task wait_pd(input logic v, input int lim);
		for (int k = 0; k < lim && powerDown !== v; k++) @(posedge ref_clk);
		check("powerDown", powerDown, v);
		if (powerDown !== v) print_verdict();
	endtask
	task pulse(input bit done);
		@(posedge ref_clk) #1;
		if (done) cycleDone = 1'b1;
		else cycleStart = 1'b1;
		@(posedge ref_clk) #1;
		cycleDone = 1'b0;
		cycleStart = 1'b0;
	endtask
	task jedec();
		u_spi_host_model.frame(OP_JEDEC, 1, 0, 24'h0, 0, 32, rd);
		check("jedec", rd, {MF, MT, CP, MF});
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_ids();
		jedec();
		u_spi_host_model.frame(OP_MFR1, 1, 24, 24'hFFFFFE, 0, 32, rd);
		check("mfr1 a0=0", rd, {MF, DV, MF, DV});
		u_spi_host_model.frame(OP_MFR1, 1, 24, 24'h000001, 0, 32, rd);
		check("mfr1 a0=1", rd, {DV, MF, DV, MF});
		u_spi_host_model.frame(OP_MFR2, 2, 12, 24'hABCDE0, 4, 16, rd);
		check("mfr2", rd, {MF, DV, MF, DV});
		u_spi_host_model.frame(OP_MFR4, 4, 6, 24'h123451, 6, 8, rd);
		check("mfr4", rd, {DV, MF, DV, MF});
		u_spi_host_model.frame(OP_RELEASE, 1, 24, 24'h0, 0, 16, rd);
		check("devid", rd, {16'h0, DV, DV});
	endtask
	task t_power();
		check("pd after reset", powerDown, 1'b0);
		u_spi_host_model.frame(OP_PDOWN, 1, 1, 24'h0, 0, 0, rd);
		repeat (20) @(posedge ref_clk);
		check("pd nine clocks", powerDown, 1'b0);
		u_spi_host_model.frame(OP_PDOWN, 1, 0, 24'h0, 0, 0, rd);
		wait_pd(1'b1, 10);
		u_spi_host_model.frame(OP_JEDEC, 1, 0, 24'h0, 0, 32, rd);
		check("silent when down", oeSeen, 1'b0);
		u_spi_host_model.frame(OP_RELEASE, 1, 0, 24'h0, 0, 0, rd);
		wait_pd(1'b0, 8);
		repeat (10) @(posedge ref_clk);
		jedec();
	endtask
	task t_busy();
		pulse(1'b0);
		check("busy set", writeInProgress, 1'b1);
		u_spi_host_model.frame(OP_PDOWN, 1, 0, 24'h0, 0, 0, rd);
		wait_pd(1'b1, 10);
		u_spi_host_model.frame(OP_RELEASE, 1, 0, 24'h0, 0, 0, rd);
		repeat (20) @(posedge ref_clk);
		check("release while busy", powerDown, 1'b1);
		check("busy kept", writeInProgress, 1'b1);
		pulse(1'b1);
		check("busy clear", writeInProgress, 1'b0);
		u_spi_host_model.frame(OP_RELEASE, 1, 24, 24'h0, 0, 8, rd);
		check("release id", rd, {24'h0, DV});
		wait_pd(1'b0, 8);
		repeat (14) @(posedge ref_clk);
		jedec();
	endtask
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		cycleStart = 1'b0;
		cycleDone = 1'b0;
		miscompares = 0;
		samplesChecked = 0;
		repeat (8) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge ref_clk);
		t_ids();
		t_power();
		t_busy();
		print_verdict();
	end
endmodule
